// ---- logic/cfsr_pkg.sv ----
// Notes on behaviour
// - each of four channels has a thermal fault flag in bits 3:0 of its register.
// - autorestart: thermal flag held while channel off unless read-and-cleared, cleared once the channel is on and overtemperature is gone.
// - latch policy: thermal flag kept until a read-and-clear hits that register.
// - on-state open-load flag set when open-load is seen with the channel on.
// - while off, the on-state open-load flag clears only by read-and-clear.
// - off-state flag set after the detection delay if output stays above threshold.
// - off-state flag means open-load or stuck-to-supply, chosen by configuration.
// - off-state flag follows the detector while off after the delay, and while on only a read-and-clear changes it.
package cfsr_pkg;

	// ==========================================================
	// register map
	localparam logic [5:0] CFSR_THERMAL_FAULT_STATUS_ADDR = 6'h30;
	localparam logic [5:0] CFSR_ON_OPEN_LOAD_STATUS_ADDR = 6'h31;
	localparam logic [5:0] CFSR_OFF_OPEN_OR_STUCK_STATUS_ADDR = 6'h32;
	localparam logic [3:0] CFSR_FLAGS_RESET = 4'h0;
	localparam logic [7:0] CFSR_READ_RESET = 8'h00;
	localparam int CFSR_CHANNELS = 4;
	localparam int CFSR_FLAG_LSB = 0;

	// ==========================================================
	// timing
	localparam int CFSR_CLK_PERIOD_PS = 4000;
	localparam int CFSR_OFF_DETECT_DELAY_PS = 1000000;
	localparam int CFSR_OFF_DETECT_CYCLES_INT = (CFSR_OFF_DETECT_DELAY_PS + CFSR_CLK_PERIOD_PS - 1) / CFSR_CLK_PERIOD_PS;
	localparam logic [15:0] CFSR_OFF_DETECT_CYCLES = CFSR_OFF_DETECT_CYCLES_INT[15:0];
	localparam logic [15:0] CFSR_COUNT_RESET = 16'h0000;
	localparam int CFSR_SYNC_STAGES = 2;

endpackage

// ---- logic/cfsr_sync.sv ----
`timescale 1ns/10ps
module cfsr_sync
	import cfsr_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// first stage is read only by the second
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta_q <= '0;
			stable_q <= '0;
		end
		else
		begin
			meta_q <= async_in;
			stable_q <= meta_q;
		end
	end

	assign sync_out = stable_q;

endmodule // cfsr_sync

// ---- logic/cfsr_status_regs.sv ----
`timescale 1ns/10ps
module cfsr_status_regs
	import cfsr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [3:0] channel_on_in,
	input wire logic latch_policy_in,
	input wire logic [3:0] off_open_load_config_in,
	input wire logic [3:0] thermal_detect_in,
	input wire logic [3:0] on_open_load_detect_in,
	input wire logic [3:0] off_above_threshold_in,
	input wire logic req_valid_in,
	input wire logic req_clear_in,
	input wire logic [5:0] req_addr_in,
	output logic [7:0] rd_data_out,
	output logic [3:0] thermal_fault_flag_out,
	output logic [3:0] on_open_load_flag_out,
	output logic [3:0] off_open_or_stuck_flag_out,
	output logic [3:0] off_fault_is_stuck_out
);

	// ==========================================================
	// reset release and detector synchronisers
	logic rst_meta_q;
	logic rst_n_q;
	logic [11:0] det_sync;
	logic [3:0] ot_det;
	logic [3:0] onol_det;
	logic [3:0] offd_det;

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	cfsr_sync #(.WIDTH(12)) u_det_sync (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n_q),
		.async_in({off_above_threshold_in, on_open_load_detect_in, thermal_detect_in}),
		.sync_out(det_sync)
	);

	assign ot_det = det_sync[3:0];
	assign onol_det = det_sync[7:4];
	assign offd_det = det_sync[11:8];

	// ==========================================================
	// read-and-clear decode
	logic rc_thermal;
	logic rc_onol;
	logic rc_stuck;

	assign rc_thermal = req_valid_in && req_clear_in && (req_addr_in == CFSR_THERMAL_FAULT_STATUS_ADDR);
	assign rc_onol = req_valid_in && req_clear_in && (req_addr_in == CFSR_ON_OPEN_LOAD_STATUS_ADDR);
	assign rc_stuck = req_valid_in && req_clear_in && (req_addr_in == CFSR_OFF_OPEN_OR_STUCK_STATUS_ADDR);

	// ==========================================================
	// per-channel flags
	logic [3:0] thermal_q;
	logic [3:0] onol_q;
	logic [3:0] stuck_q;
	logic [3:0] kind_q;
	logic [15:0] off_cnt_q [CFSR_CHANNELS];
	logic [3:0] off_ready;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_q);

	genvar ch;
	generate
		for (ch = 0; ch < CFSR_CHANNELS; ch++)
		begin : g_ch
			assign off_ready[ch] = (off_cnt_q[ch] == CFSR_OFF_DETECT_CYCLES);

			// delay restarts on every turn-off; saturates so the flag then tracks the detector
			always_ff @(posedge ref_clk_in or negedge rst_n_q)
			begin
				if (!rst_n_q)
					off_cnt_q[ch] <= CFSR_COUNT_RESET;
				else if (channel_on_in[ch])
					off_cnt_q[ch] <= CFSR_COUNT_RESET;
				else if (!off_ready[ch])
					off_cnt_q[ch] <= off_cnt_q[ch] + 16'h0001;
			end

			// set wins over any clear in the same cycle
			always_ff @(posedge ref_clk_in or negedge rst_n_q)
			begin
				if (!rst_n_q)
					thermal_q[ch] <= 1'b0;
				else if (ot_det[ch])
					thermal_q[ch] <= 1'b1;
				else if (rc_thermal)
					thermal_q[ch] <= 1'b0;
				else if (!latch_policy_in && channel_on_in[ch])
					thermal_q[ch] <= 1'b0;
			end

			always_ff @(posedge ref_clk_in or negedge rst_n_q)
			begin
				if (!rst_n_q)
					onol_q[ch] <= 1'b0;
				else if (channel_on_in[ch])
					onol_q[ch] <= onol_det[ch];
				else if (rc_onol)
					onol_q[ch] <= 1'b0;
			end

			// before the delay runs out only a read-and-clear changes the off-state flag's frozen value
			always_ff @(posedge ref_clk_in or negedge rst_n_q)
			begin
				if (!rst_n_q)
					stuck_q[ch] <= 1'b0;
				else if (!channel_on_in[ch] && off_ready[ch])
					stuck_q[ch] <= offd_det[ch];
				else if (rc_stuck)
					stuck_q[ch] <= 1'b0;
			end

			sequence s_off_settled;
				!channel_on_in[ch] && off_ready[ch];
			endsequence

			sequence s_on_no_clear;
				channel_on_in[ch] && !rc_stuck;
			endsequence

			a_thermal_set: assert property (ot_det[ch] |=> thermal_q[ch])
				else $error("thermal flag not set by detector");
			a_auto_hold: assert property (!latch_policy_in && thermal_q[ch] && !channel_on_in[ch] && !rc_thermal
				|=> thermal_q[ch])
				else $error("autorestart thermal flag lost while off");
			a_auto_clear: assert property (!latch_policy_in && channel_on_in[ch] && !ot_det[ch]
				|=> !thermal_q[ch])
				else $error("autorestart thermal flag not cleared");
			a_latch_keep: assert property (latch_policy_in && thermal_q[ch] && !rc_thermal
				|=> thermal_q[ch])
				else $error("latched thermal flag lost");
			a_thermal_rc: assert property (rc_thermal && !ot_det[ch] |=> !thermal_q[ch])
				else $error("thermal flag survived read-and-clear");
			a_onol_follow: assert property (channel_on_in[ch] |=> onol_q[ch] == $past(onol_det[ch]))
				else $error("on-state flag does not follow detector");
			a_onol_off_hold: assert property (!channel_on_in[ch] && !rc_onol |=> $stable(onol_q[ch]))
				else $error("on-state flag changed while off");
			a_off_delay_set: assert property (s_off_settled ##0 offd_det[ch] |=> stuck_q[ch])
				else $error("off-state flag not set after delay");
			a_off_early_hold: assert property (!channel_on_in[ch] && !off_ready[ch] && !rc_stuck
				|=> $stable(stuck_q[ch]))
				else $error("off-state flag changed before delay");
			a_off_frozen_on: assert property (s_on_no_clear |=> $stable(stuck_q[ch]))
				else $error("off-state flag not frozen while on");
			a_stuck_rc_on: assert property (channel_on_in[ch] && rc_stuck |=> !stuck_q[ch])
				else $error("off-state flag survived read-and-clear");
			a_onol_rc_off: assert property (!channel_on_in[ch] && rc_onol |=> !onol_q[ch])
				else $error("on-state flag survived read-and-clear while off");
			a_off_track: assert property (s_off_settled |=> stuck_q[ch] == $past(offd_det[ch]))
				else $error("off-state flag does not follow detector while off");
		end
	endgenerate

	// ==========================================================
	// off-state fault kind
	always_ff @(posedge ref_clk_in or negedge rst_n_q)
	begin
		if (!rst_n_q)
			kind_q <= CFSR_FLAGS_RESET;
		else
			kind_q <= off_open_load_config_in;
	end

	// no history yet at the first edge after reset release, when the mirror still holds its reset value
	a_kind_follow: assert property ($past(rst_n_q)
		|-> off_fault_is_stuck_out == $past(off_open_load_config_in))
		else $error("fault kind does not follow configuration");

	// ==========================================================
	// read data: captured before the clear lands; unmapped reads zero
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;

	always_comb
	begin
		rd_data_d = CFSR_READ_RESET;
		case (req_addr_in)
			CFSR_THERMAL_FAULT_STATUS_ADDR: rd_data_d[CFSR_FLAG_LSB +: 4] = thermal_q;
			CFSR_ON_OPEN_LOAD_STATUS_ADDR: rd_data_d[CFSR_FLAG_LSB +: 4] = onol_q;
			CFSR_OFF_OPEN_OR_STUCK_STATUS_ADDR: rd_data_d[CFSR_FLAG_LSB +: 4] = stuck_q;
			default: rd_data_d = CFSR_READ_RESET;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_q)
	begin
		if (!rst_n_q)
			rd_data_q <= CFSR_READ_RESET;
		else if (req_valid_in)
			rd_data_q <= rd_data_d;
	end

	a_reserved_zero: assert property (rd_data_q[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	a_read_value: assert property (req_valid_in && req_addr_in == CFSR_THERMAL_FAULT_STATUS_ADDR
		|=> rd_data_q[3:0] == $past(thermal_q))
		else $error("thermal read data wrong");

	assign rd_data_out = rd_data_q;
	assign thermal_fault_flag_out = thermal_q;
	assign on_open_load_flag_out = onol_q;
	assign off_open_or_stuck_flag_out = stuck_q;
	assign off_fault_is_stuck_out = kind_q;

endmodule // cfsr_status_regs

// ---- sim/cfsr_host_model.sv ----
`timescale 1ns/10ps
module cfsr_host_model
(
	input wire logic clk_in,
	output logic req_valid_out,
	output logic req_clear_out,
	output logic [5:0] req_addr_out,
	input wire logic [7:0] rd_data_in
);
	// ==========================================================
	// host access: request held over one rising edge, then released
	initial
	begin
		req_valid_out = 1'b0;
		req_clear_out = 1'b0;
		req_addr_out = 6'h00;
	end
	task automatic access(input logic [5:0] addr, input logic clr, output logic [7:0] data);
		@(negedge clk_in);
		req_valid_out = 1'b1;
		req_clear_out = clr;
		req_addr_out = addr;
		@(negedge clk_in);
		req_valid_out = 1'b0;
		// released qualifiers must not keep looking valid
		req_clear_out = ~clr;
		req_addr_out = ~addr;
		@(negedge clk_in);
		data = rd_data_in;
	endtask
endmodule // cfsr_host_model

// ---- sim/test_channel_fault_status_regs.sv ----
`timescale 1ns/10ps
module test_channel_fault_status_regs;
	import cfsr_pkg::*;
	localparam logic [5:0] ADR_T = CFSR_THERMAL_FAULT_STATUS_ADDR;
	localparam logic [5:0] ADR_O = CFSR_ON_OPEN_LOAD_STATUS_ADDR;
	localparam logic [5:0] ADR_S = CFSR_OFF_OPEN_OR_STUCK_STATUS_ADDR;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic latch = 1'b0;
	logic [3:0] chan = 4'h0, cfg = 4'h0, thd = 4'h0, old = 4'h0, abv = 4'h0;
	logic rv, rc;
	logic [5:0] ra;
	logic [7:0] rd;
	logic [3:0] th, onf, off, stk;
	int err_count = 0;
	int num_checks = 0;
	always #2 clk = ~clk;
	cfsr_status_regs uut (.ref_clk_in(clk), .resetn_in(resetn), .channel_on_in(chan), .latch_policy_in(latch),
		.off_open_load_config_in(cfg), .thermal_detect_in(thd), .on_open_load_detect_in(old),
		.off_above_threshold_in(abv), .req_valid_in(rv), .req_clear_in(rc), .req_addr_in(ra),
		.rd_data_out(rd), .thermal_fault_flag_out(th), .on_open_load_flag_out(onf),
		.off_open_or_stuck_flag_out(off), .off_fault_is_stuck_out(stk));
	cfsr_host_model host (.clk_in(clk), .req_valid_out(rv), .req_clear_out(rc), .req_addr_out(ra), .rd_data_in(rd));
	// ==========================================================
	// helpers
	task automatic conclude();
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [5:0] a, input logic c, input logic [7:0] exp);
		logic [7:0] d;
		host.access(a, c, d);
		chk(d, exp);
	endtask
	// three edges of detector latency plus margin
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		rdc(ADR_T, 1'b0, 8'h00);
		rdc(ADR_O, 1'b0, 8'h00);
		rdc(ADR_S, 1'b0, 8'h00);
		rdc(6'h33, 1'b1, 8'h00);
	endtask
	task automatic t_auto();
		thd = 4'h1;
		cyc(5);
		chk({4'h0, th}, 8'h01);
		thd = 4'h0;
		cyc(5);
		rdc(ADR_T, 1'b0, 8'h01);
		chan = 4'h1;
		cyc(5);
		chk({4'h0, th}, 8'h00);
		chan = 4'h0;
	endtask
	task automatic t_latch();
		latch = 1'b1;
		thd = 4'h8;
		cyc(5);
		thd = 4'h0;
		chan = 4'h8;
		cyc(5);
		rdc(ADR_O, 1'b1, 8'h00);
		chk({4'h0, th}, 8'h08);
		rdc(ADR_T, 1'b1, 8'h08);
		chk({4'h0, th}, 8'h00);
		latch = 1'b0;
		chan = 4'h0;
	endtask
	task automatic t_on();
		chan = 4'h2;
		old = 4'h2;
		cyc(5);
		chk({4'h0, onf}, 8'h02);
		old = 4'h0;
		cyc(5);
		chk({4'h0, onf}, 8'h00);
		old = 4'h2;
		cyc(5);
		chk({4'h0, onf}, 8'h02);
		chan = 4'h0;
		old = 4'h0;
		cyc(5);
		rdc(ADR_O, 1'b0, 8'h02);
		rdc(ADR_O, 1'b1, 8'h02);
		chk({4'h0, onf}, 8'h00);
	endtask
	task automatic t_off();
		cfg = 4'h4;
		chan = 4'h4;
		cyc(2);
		chan = 4'h0;
		abv = 4'h4;
		cyc(100);
		chk({4'h0, off}, 8'h00);
		chk({4'h0, stk}, 8'h04);
		cyc(160);
		chk({4'h0, off}, 8'h04);
		abv = 4'h0;
		cyc(5);
		chk({4'h0, off}, 8'h00);
		abv = 4'h4;
		cyc(5);
		chan = 4'h4;
		abv = 4'h0;
		cyc(5);
		chk({4'h0, off}, 8'h04);
		rdc(ADR_S, 1'b1, 8'h04);
		chk({4'h0, off}, 8'h00);
		cfg = 4'h0;
		cyc(3);
		chk({4'h0, stk}, 8'h00);
	endtask
	initial
	begin
		cyc(10);
		resetn = 1'b1;
		cyc(5);
		t_reset();
		t_auto();
		t_latch();
		t_on();
		t_off();
		conclude();
	end
	initial
	begin
		#100000;
		err_count++;
		conclude();
	end
endmodule // test_channel_fault_status_regs
